// ### inc/twm_defines.vh
// Notes on behaviour
// R01 - Completion flag rises after every handled bus event except STOP.
// R02 - Interrupt only when flag set, local enable and global enable all set; irq_out follows irq_stat and irq_mask alone.
// R03 - With local enable clear, software polls the completion flag.
// R04 - Writing one to flag bit clears it; writing zero leaves it.
// R05 - No new bus operation starts while the completion flag is set.
// R06 - Clearing flag with START requested begins START at once.
// R07 - After START goes out, flag sets and START status posts.
// R08 - After address byte goes out, flag sets and address status posts.
// R09 - After data byte goes out, flag sets and data status posts.
// R10 - Address and data status codes show ACK or NACK from slave.
// R11 - STOP is sent on request and does not set the flag.
// R12 - Serial clock held low while completion flag is set.
// R13 - While flag is set, status holds code of present bus state.
// R14 - Software loads shift data byte before clearing the flag.
// R15 - One shift data byte serves both address and data.
// R16 - Control write with flag bit set runs the selected operation.
// R17 - Software checks status after each step and handles errors.
// R18 - Status code updates in the cycle after the flag rises.
// R19 - While flag is clear, status holds the no-information code.
`ifndef TWM_DEFINES_VH
`define TWM_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TWM_ADDR_CONTROL 4'h0
`define TWM_ADDR_STATUS 4'h1
`define TWM_ADDR_DATA 4'h2
`define TWM_ADDR_DIVIDER 4'h3
`define TWM_ADDR_IRQ_STAT 4'h4
`define TWM_ADDR_IRQ_MASK 4'h5
// ----------------------------------------
// Control word fields
// ----------------------------------------
`define TWM_CTL_IRQ_EN 0
`define TWM_CTL_ENABLE 2
`define TWM_CTL_STOP 4
`define TWM_CTL_START 5
`define TWM_CTL_FLAG 7
// ----------------------------------------
// Status codes
// ----------------------------------------
`define TWM_ST_START 8'h08
`define TWM_ST_ADDR_ACK 8'h18
`define TWM_ST_ADDR_NACK 8'h20
`define TWM_ST_DATA_ACK 8'h28
`define TWM_ST_DATA_NACK 8'h30
`define TWM_ST_NONE 8'hF8
// ----------------------------------------
// Reset values, timing and interrupt status bits
// ----------------------------------------
`define TWM_DIV_RESET 8'h0F
`define TWM_IRQ_BIT_DONE 0
`define TWM_IRQ_BIT_NACK 1
`endif

// ### hdl/twm_master.v
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "twm_defines.vh"
module twm_master (
  input wire core_clk_in,
  input wire nrst_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire global_irq_enable_in,
  input wire scl_in,
  input wire sda_in,
  output reg [7:0] rdata_out,
  output reg scl_out,
  output reg scl_oe_n_out,
  output reg sda_out,
  output reg sda_oe_n_out,
  output reg done_irq_out,
  output reg irq_out
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_START = 6'b000010;
  localparam [5:0] ST_BITS = 6'b000100;
  localparam [5:0] ST_ACK = 6'b001000;
  localparam [5:0] ST_STOP = 6'b010000;
  localparam [5:0] ST_WAIT = 6'b100000;

  reg [5:0] state;
  reg [7:0] shift_data_byte;
  reg [7:0] tx_shift;
  reg [7:0] status_word;
  reg [7:0] divider;
  reg [7:0] div_cnt;
  reg tick;
  reg [1:0] phase;
  reg [2:0] bit_cnt;
  reg flag;
  reg flag_d;
  reg op_done_irq_enable;
  reg unit_enable;
  reg sent_addr;
  reg got_nack;
  reg [7:0] pend_code;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg scl_s1;
  reg scl_s2;
  reg sda_s1;
  reg sda_s2;
  reg drive_scl_low;
  reg drive_sda_low;
  reg flag_set;
  wire [1:0] ev_set;
  wire ctl_wr;
  wire flag_clear;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  // ----------------------------------------
  // Quarter-bit enable divider
  // ----------------------------------------
  // Slave stretching: phase does not advance while SCL is released but low
  wire stretched = (phase == 2'd2) && !scl_s2;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (state == ST_IDLE || state == ST_WAIT || stretched) begin
        div_cnt <= 8'h00;
      end else if (div_cnt >= divider) begin
        div_cnt <= 8'h00;
        tick <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  assign ctl_wr = wr_in && (addr_in == `TWM_ADDR_CONTROL);
  assign flag_clear = ctl_wr && wdata_in[`TWM_CTL_FLAG]; // [R04]
  // NACK event follows the posted code, one cycle after the flag pulse
  assign ev_set = {flag_d && (pend_code == `TWM_ST_ADDR_NACK || pend_code == `TWM_ST_DATA_NACK),
    flag_set};

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      phase <= 2'd0;
      bit_cnt <= 3'd0;
      tx_shift <= 8'h00;
      drive_scl_low <= 1'b0;
      drive_sda_low <= 1'b0;
      sent_addr <= 1'b0;
      got_nack <= 1'b0;
      flag_set <= 1'b0;
      pend_code <= `TWM_ST_NONE;
    end else begin
      flag_set <= 1'b0;
      case (state)
        ST_IDLE, ST_WAIT: begin
          // Start/stop only leave here once the flag is cleared
          // Written enable counts, so one write can both enable and start
          if (flag_clear && wdata_in[`TWM_CTL_ENABLE] && (state == ST_IDLE || flag)) begin // [R05] [R16]
            phase <= 2'd0;
            if (wdata_in[`TWM_CTL_START]) begin
              state <= ST_START; // [R06]
              sent_addr <= 1'b0;
            end else if (wdata_in[`TWM_CTL_STOP]) begin
              state <= ST_STOP; // [R11]
            end else if (state == ST_WAIT) begin
              state <= ST_BITS;
              tx_shift <= shift_data_byte; // [R15]
              bit_cnt <= 3'd7;
            end
          end
        end
        ST_START: begin
          if (tick) begin
            phase <= phase + 2'd1;
            if (phase == 2'd1) drive_sda_low <= 1'b1;
            if (phase == 2'd3) begin
              drive_scl_low <= 1'b1;
              state <= ST_WAIT;
              flag_set <= 1'b1; // [R07] [R01]
              pend_code <= `TWM_ST_START;
            end
          end
        end
        ST_BITS: begin
          if (tick) begin
            phase <= phase + 2'd1;
            case (phase)
              2'd0: drive_sda_low <= !tx_shift[7];
              2'd1: drive_scl_low <= 1'b0;
              2'd3: begin
                drive_scl_low <= 1'b1;
                tx_shift <= {tx_shift[6:0], 1'b0};
                bit_cnt <= bit_cnt - 3'd1;
                if (bit_cnt == 3'd0) state <= ST_ACK;
              end
              default: drive_scl_low <= drive_scl_low;
            endcase
          end
        end
        ST_ACK: begin
          if (tick) begin
            phase <= phase + 2'd1;
            case (phase)
              2'd0: drive_sda_low <= 1'b0;
              2'd1: drive_scl_low <= 1'b0;
              2'd2: got_nack <= sda_s2; // [R10]
              default: begin
                drive_scl_low <= 1'b1;
                drive_sda_low <= 1'b0;
                state <= ST_WAIT;
                sent_addr <= 1'b1;
                flag_set <= 1'b1; // [R01]
                if (!sent_addr) begin
                  pend_code <= got_nack ? `TWM_ST_ADDR_NACK : `TWM_ST_ADDR_ACK; // [R08] [R10]
                end else begin
                  pend_code <= got_nack ? `TWM_ST_DATA_NACK : `TWM_ST_DATA_ACK; // [R09] [R10]
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (tick) begin
            phase <= phase + 2'd1;
            case (phase)
              2'd0: drive_sda_low <= 1'b1;
              2'd1: drive_scl_low <= 1'b0;
              2'd2: drive_sda_low <= 1'b0;
              default: state <= ST_IDLE; // Flag stays clear after STOP [R11]
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Completion flag and status
  // ----------------------------------------
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag <= 1'b0;
      flag_d <= 1'b0;
      status_word <= `TWM_ST_NONE;
    end else begin
      // Set wins over a clear in the same cycle
      if (flag_set) flag <= 1'b1; // [R01]
      else if (flag_clear) flag <= 1'b0; // [R04]
      flag_d <= flag_set;
      if (flag_d && flag) status_word <= pend_code; // [R18] [R13]
      else if (!flag) status_word <= `TWM_ST_NONE; // [R19]
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_done_irq_enable <= 1'b0;
      unit_enable <= 1'b0;
      shift_data_byte <= 8'h00;
      divider <= `TWM_DIV_RESET;
      irq_mask <= 2'h0;
      irq_stat <= 2'h0;
    end else begin
      if (ctl_wr) begin
        op_done_irq_enable <= wdata_in[`TWM_CTL_IRQ_EN];
        unit_enable <= wdata_in[`TWM_CTL_ENABLE];
      end
      // Software is expected to load this only while the flag is set
      if (wr_in && addr_in == `TWM_ADDR_DATA) shift_data_byte <= wdata_in; // [R14]
      if (wr_in && addr_in == `TWM_ADDR_DIVIDER) divider <= wdata_in;
      if (wr_in && addr_in == `TWM_ADDR_IRQ_MASK) irq_mask <= wdata_in[1:0];
      if (wr_in && addr_in == `TWM_ADDR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wdata_in[1:0]) | ev_set;
      end else begin
        irq_stat <= irq_stat | ev_set;
      end
    end
  end

  // ----------------------------------------
  // Read port and outputs
  // ----------------------------------------
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
      scl_out <= 1'b0;
      scl_oe_n_out <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      done_irq_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      rdata_out <= 8'h00;
      if (rd_in) begin
        if (addr_in == `TWM_ADDR_CONTROL) begin
          rdata_out <= {flag, 1'b0, 1'b0, 1'b0, 1'b0, unit_enable, 1'b0, op_done_irq_enable};
        end else if (addr_in == `TWM_ADDR_STATUS) begin
          rdata_out <= status_word;
        end else if (addr_in == `TWM_ADDR_DATA) begin
          rdata_out <= shift_data_byte;
        end else if (addr_in == `TWM_ADDR_DIVIDER) begin
          rdata_out <= divider;
        end else if (addr_in == `TWM_ADDR_IRQ_STAT) begin
          rdata_out <= {6'h00, irq_stat};
        end else if (addr_in == `TWM_ADDR_IRQ_MASK) begin
          rdata_out <= {6'h00, irq_mask};
        end
      end
      // Clock held low while software owns the flag
      scl_oe_n_out <= !(drive_scl_low || flag); // [R12]
      sda_oe_n_out <= !drive_sda_low;
      done_irq_out <= flag && op_done_irq_enable && global_irq_enable_in; // [R02]
      irq_out <= |(irq_stat & irq_mask);
    end
  end
endmodule // twm_master

// ### bench/twm_monitor.sv
`timescale 1ns/100ps
module twm_monitor (
  input wire core_clk_in,
  input wire nrst_in,
  input wire [3:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire global_irq_enable_in,
  input wire [7:0] rdata_out,
  input wire scl_oe_n_out,
  input wire sda_oe_n_out,
  input wire done_irq_out,
  input wire irq_out
);
  // ------------------------------
  // Port relations
  // ------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_gate; done_irq_out |-> $past(global_irq_enable_in); endproperty
  a_gate: assert property (p_gate) else $error("done irq without enable");
  // Skip the cycle after a write: the flag may just have been cleared
  property p_stretch; done_irq_out && $past(done_irq_out) && !$past(wr_in)
    |-> !scl_oe_n_out; endproperty
  a_stretch: assert property (p_stretch) else $error("scl free while flagged");
  property p_hold; done_irq_out && $past(done_irq_out) && !$past(wr_in)
    |-> $stable(sda_oe_n_out); endproperty
  a_hold: assert property (p_hold) else $error("sda moved while flagged");
  property p_done_fall; $fell(done_irq_out)
    |-> $past(wr_in) || $past(wr_in, 2) || !$past(global_irq_enable_in); endproperty
  a_done_fall: assert property (p_done_fall) else $error("flag fell unasked");
  property p_irq_fall; $fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
  property p_stop; $rose(sda_oe_n_out) && scl_oe_n_out |-> (!done_irq_out) [*8]; endproperty
  a_stop: assert property (p_stop) else $error("flag after stop");
  property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped; $past(rd_in) && $past(addr_in) > 4'h5 |-> rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // twm_monitor

bind twm_master twm_monitor u_mon (.*);

// ### bench/twm_slave.sv
`timescale 1ns/100ps
module twm_slave (
  input wire scl_in,
  input wire sda_in,
  input wire nack_in,
  output logic sda_oe_n_out,
  output logic [7:0] last_out
);
  logic [7:0] shift = 8'h00;
  int bit_cnt = -1;
  initial sda_oe_n_out = 1'b1;
  initial last_out = 8'h00;
  // ------------------------------
  // Framing seen as SDA edges while SCL is high
  // ------------------------------
  always @(negedge sda_in) if (scl_in) bit_cnt = 0;
  always @(posedge sda_in) if (scl_in) bit_cnt = -1;
  always @(posedge scl_in) begin
    if (bit_cnt >= 0 && bit_cnt < 8) begin
      shift = {shift[6:0], sda_in};
      bit_cnt++;
      if (bit_cnt == 8) last_out = shift;
    end
  end
  // Answer bit changes only while SCL is low, then released to the pull-up
  always @(negedge scl_in) begin
    if (bit_cnt == 8) begin
      sda_oe_n_out = nack_in;
      bit_cnt = 9;
    end else if (bit_cnt == 9) begin
      sda_oe_n_out = 1'b1;
      bit_cnt = 0;
    end
  end
endmodule // twm_slave

// ### bench/twm_master_tb.sv
`timescale 1ns/100ps
`include "twm_defines.vh"
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module twm_master_tb;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic gie = 1'b1;
  logic nack = 1'b0;
  logic [7:0] rv;
  wire [7:0] rdata_out;
  wire [7:0] last_byte;
  wire scl_oe_n, sda_oe_n, slv_oe_n, done_irq, irq;
  wire scl_lvl, sda_lvl;
  // Both lines have pull-ups: a released line reads high
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & slv_oe_n;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  twm_master dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .global_irq_enable_in(gie),
    .scl_in(scl), .sda_in(sda), .rdata_out(rdata_out), .scl_out(scl_lvl),
    .scl_oe_n_out(scl_oe_n), .sda_out(sda_lvl), .sda_oe_n_out(sda_oe_n),
    .done_irq_out(done_irq), .irq_out(irq));
  twm_slave u_slave (.scl_in(scl), .sda_in(sda), .nack_in(nack), .sda_oe_n_out(slv_oe_n),
    .last_out(last_byte));
  initial forever #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // ------------------------------
  // Bus tasks
  // ------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic step(input logic [7:0] ctl, input logic [7:0] code);
    wr(`TWM_ADDR_CONTROL, ctl);
    // Forget the flag seen before this step
    rv = 8'h00;
    for (int i = 0; i < 300 && rv[`TWM_CTL_FLAG] !== 1'b1; i++)
      rd(`TWM_ADDR_CONTROL, rv);
    `CHK(rv[`TWM_CTL_FLAG], 1'b1)
    `CHK(done_irq, gie)
    `CHK(scl_oe_n, 1'b0)
    rd(`TWM_ADDR_STATUS, rv);
    `CHK(rv, code)
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs;
    wr(`TWM_ADDR_STATUS, 8'h00);
    rd(`TWM_ADDR_STATUS, rv);
    `CHK(rv, `TWM_ST_NONE)
    rd(4'hF, rv);
    `CHK(rv, 8'h00)
    `CHK({scl_lvl, sda_lvl}, 2'b00)
    rd(`TWM_ADDR_DIVIDER, rv);
    `CHK(rv, `TWM_DIV_RESET)
    // Quarter bit of two cycles gives the 160 ns link period
    wr(`TWM_ADDR_DIVIDER, 8'h01);
  endtask
  task automatic t_xfer(input logic nk);
    nack <= nk;
    wr(`TWM_ADDR_DATA, 8'hC6);
    rv = 8'h00;
    step(8'hA5, `TWM_ST_START);
    wr(`TWM_ADDR_CONTROL, 8'h05);
    repeat (40) @(posedge core_clk_in);
    rd(`TWM_ADDR_CONTROL, rv);
    `CHK(rv[`TWM_CTL_FLAG], 1'b1)
    `CHK({scl_oe_n, sda_oe_n}, 2'b00)
    wr(`TWM_ADDR_DATA, 8'hA0);
    step(8'h85, nk ? `TWM_ST_ADDR_NACK : `TWM_ST_ADDR_ACK);
    `CHK(last_byte, 8'hA0)
    wr(`TWM_ADDR_DATA, 8'h3C);
    step(8'h85, nk ? `TWM_ST_DATA_NACK : `TWM_ST_DATA_ACK);
    `CHK(last_byte, 8'h3C)
    wr(`TWM_ADDR_CONTROL, 8'h95);
    for (int i = 0; i < 400 && !(scl_oe_n && sda_oe_n); i++) @(posedge core_clk_in);
    `CHK({scl_oe_n, sda_oe_n}, 2'b11)
    repeat (100) @(posedge core_clk_in);
    rd(`TWM_ADDR_CONTROL, rv);
    `CHK(rv[`TWM_CTL_FLAG], 1'b0)
    rd(`TWM_ADDR_STATUS, rv);
    `CHK(rv, `TWM_ST_NONE)
  endtask
  task automatic t_irq;
    `CHK(irq, 1'b0)
    rd(`TWM_ADDR_IRQ_STAT, rv);
    `CHK(rv, 8'h03)
    wr(`TWM_ADDR_IRQ_MASK, 8'h02);
    rd(`TWM_ADDR_IRQ_STAT, rv);
    `CHK(irq, 1'b1)
    wr(`TWM_ADDR_IRQ_STAT, 8'h02);
    rd(`TWM_ADDR_IRQ_STAT, rv);
    `CHK(rv, 8'h01)
    `CHK(irq, 1'b0)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_xfer(1'b0);
    // Local enable stays set, so only the global gate keeps the line low
    gie <= 1'b0;
    t_xfer(1'b1);
    t_irq();
    complete_run();
  end
endmodule // twm_master_tb
